/* File: core/fmnd_pkg.sv */
// Package: encodings, offsets and carriers of the fp move/mul/neg decoder
package fmnd_pkg;

    // ------------------------------------------------------------
    // Instruction match masks and values
    // ------------------------------------------------------------
    localparam logic [31:0] M_SGL  = 32'hFFE00F7F;
    localparam logic [31:0] V_SGL  = 32'hEE000A10;
    localparam logic [31:0] M_PAIR = 32'hFFE00FD0;
    localparam logic [31:0] V_PAIR = 32'hEC400A10;
    localparam logic [31:0] V_DBL  = 32'hEC400B10;
    localparam logic [31:0] M_STAT = 32'hFFFF0FFF;
    localparam logic [31:0] V_SRD  = 32'hEEF10A10;
    localparam logic [31:0] V_SWR  = 32'hEEE10A10;
    localparam logic [31:0] M_MUL  = 32'hFFB00F50;
    localparam logic [31:0] V_MUL  = 32'hEE200A00;
    localparam logic [31:0] M_NEG  = 32'hFFBF0FD0;
    localparam logic [31:0] V_NEG  = 32'hEEB10A40;

    // ------------------------------------------------------------
    // Field positions and special indices
    // ------------------------------------------------------------
    localparam int DIR_BIT = 20;
    localparam int RT_LSB  = 12;
    localparam int RT2_LSB = 16;
    localparam int VA_LSB  = 16;
    localparam int VD_LSB  = 12;
    localparam int VB_LSB  = 0;
    localparam int XA_BIT  = 7;
    localparam int XB_BIT  = 5;
    localparam int XD_BIT  = 22;
    localparam int NZCV_LSB = 28;
    localparam logic [3:0] REG_PC = 4'hF;
    localparam logic [3:0] REG_SP = 4'hD;
    localparam logic [4:0] SREG_LAST = 5'h1F;

    // ------------------------------------------------------------
    // Register offsets, event bits, reset values
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_FSC  = 8'h04;
    localparam logic [7:0] A_EVT  = 8'h08;
    localparam logic [7:0] A_MASK = 8'h0C;
    localparam int EV_UNDEF = 0;
    localparam int EV_UNPRED = 1;
    localparam int EV_FPX = 2;
    localparam int EV_W = 7;
    localparam logic        EN_RST   = 1'b0;
    localparam logic [31:0] FSC_RST  = 32'h0000_0000;
    localparam logic [6:0]  MASK_RST = 7'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] instr;
        logic        cond_pass;
        logic [31:0] rt_val;
        logic [31:0] rt2_val;
    } fmnd_issue_s;

    typedef struct packed {
        logic        va;
        logic [3:0]  ia;
        logic [31:0] da;
        logic        vb;
        logic [3:0]  ib;
        logic [31:0] db;
    } fmnd_cwr_s;

    typedef struct packed {
        logic       v;
        logic [3:0] nzcv;
    } fmnd_flg_s;

    typedef enum logic [0:0] {ST_RUN, ST_DRAIN} fmnd_st_e;

endpackage

/* File: core/fmnd_fmul.sv */
// Single-precision multiplier with flush-to-zero and exception flags
`timescale 1ns/1ps
module fmnd_fmul
(
    input  wire logic [31:0] a,
    input  wire logic [31:0] b,
    output logic      [31:0] y,
    output logic      [4:0]  exc
);
    import fmnd_pkg::*;

    logic [47:0] prod;
    logic [9:0]  ex;
    logic        az, bz, ai, bi, an, bn, sg;

    // ------------------------------------------------------------
    // Classify, multiply, truncate
    // ------------------------------------------------------------
    // Exc order: denormal, invalid, overflow, underflow, inexact.
    // Rounding is toward zero; trades accuracy for a small datapath.
    always_comb
    begin
        exc  = 5'h00;
        sg   = a[31] ^ b[31];
        az   = (a[30:23] == 8'h00);
        bz   = (b[30:23] == 8'h00);
        ai   = (a[30:23] == 8'hFF) && (a[22:0] == 23'h0);
        bi   = (b[30:23] == 8'hFF) && (b[22:0] == 23'h0);
        an   = (a[30:23] == 8'hFF) && (a[22:0] != 23'h0);
        bn   = (b[30:23] == 8'hFF) && (b[22:0] != 23'h0);
        exc[4] = (az && a[22:0] != 23'h0) || (bz && b[22:0] != 23'h0);
        prod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
        ex   = {2'h0, a[30:23]} + {2'h0, b[30:23]} + {9'h0, prod[47]}
             - 10'd127;
        if (an || bn)
        begin
            y = 32'h7FC0_0000;
            exc[3] = (an && !a[22]) || (bn && !b[22]);
        end
        else if ((ai && bz) || (bi && az))
        begin
            y = 32'h7FC0_0000;
            exc[3] = 1'b1;
        end
        else if (ai || bi)
            y = {sg, 8'hFF, 23'h0};
        else if (az || bz)
            y = {sg, 31'h0};
        else if (!ex[9] && ex[8:0] >= 9'd255)
        begin
            y = {sg, 8'hFF, 23'h0};
            exc[2] = 1'b1;
            exc[0] = 1'b1;
        end
        else if (ex[9] || ex == 10'd0)
        begin
            y = {sg, 31'h0};
            exc[1] = 1'b1;
            exc[0] = 1'b1;
        end
        else
        begin
            y = prod[47] ? {sg, ex[7:0], prod[46:24]}
                         : {sg, ex[7:0], prod[45:23]};
            exc[0] = prod[47] ? (prod[23:0] != 24'h0)
                              : (prod[22:0] != 23'h0);
        end
    end

endmodule

/* File: core/fmnd_core.sv */
// Decode/execute of fp moves, status moves, multiply and negate
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module fmnd_core
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic                       irq,
    input  wire logic                  issue_valid,
    input  wire fmnd_pkg::fmnd_issue_s issue,
    output logic                       issue_ready,
    output fmnd_pkg::fmnd_cwr_s        core_wr,
    output fmnd_pkg::fmnd_flg_s        flags_wr,
    output logic                       undef,
    output logic                       done,
    output logic      [4:0]            fp_exc
);
    import fmnd_pkg::*;

    typedef struct packed {
        logic [31:0][31:0] bank;
        logic [31:0]       fsc;
        logic              en;
        logic [EV_W-1:0]   evt;
        logic [EV_W-1:0]   mask;
        fmnd_st_e          st;
        fmnd_issue_s       pend;
        logic              ph_v;
        logic              ph_w;
        logic [7:0]        ph_a;
        logic [31:0]       rdat;
        fmnd_cwr_s         cwr;
        fmnd_flg_s         flg;
        logic              undef;
        logic              done;
        logic [4:0]        fpx;
    } fmnd_state_s;

    fmnd_state_s     q;
    fmnd_state_s     d;
    fmnd_issue_s     cur;
    logic [31:0]     ins;
    logic            acc;
    logic            go;
    logic            live;
    logic            dir;
    logic [3:0]      t;
    logic [3:0]      t2;
    logic [4:0]      sa;
    logic [4:0]      sb;
    logic [4:0]      sb1;
    logic [4:0]      sd;
    logic [4:0]      dm;
    logic [4:0]      dlo;
    logic [4:0]      dhi;
    logic            bad_t;
    logic            bad_t2;
    logic            unp;
    logic            is_sgl;
    logic            is_pair;
    logic            is_dbl;
    logic            is_srd;
    logic            is_swr;
    logic            is_mul;
    logic            is_neg;
    logic [31:0]     src_a;
    logic [31:0]     src_b;
    logic [31:0]     src_b1;
    logic [31:0]     neg_val;
    logic [31:0]     mul_y;
    logic [4:0]      mul_x;
    logic [EV_W-1:0] set;
    logic [EV_W-1:0] clr;

    // ------------------------------------------------------------
    // Field extraction and decode
    // ------------------------------------------------------------
    // A drained status op replays from the held copy, not the port
    assign cur     = (q.st == ST_DRAIN) ? q.pend : issue;
    assign ins     = cur.instr;
    assign acc     = issue_valid && issue_ready;
    assign dir     = ins[DIR_BIT];
    assign t       = ins[RT_LSB +: 4];
    assign t2      = ins[RT2_LSB +: 4];
    assign sa      = {ins[VA_LSB +: 4], ins[XA_BIT]};
    assign sb      = {ins[VB_LSB +: 4], ins[XB_BIT]};
    assign sb1     = sb + 5'd1;
    assign sd      = {ins[VD_LSB +: 4], ins[XD_BIT]};
    assign dm      = {ins[XB_BIT], ins[VB_LSB +: 4]};
    assign dlo     = {dm[3:0], 1'b0};
    assign dhi     = {dm[3:0], 1'b1};
    assign is_sgl  = (ins & M_SGL) == V_SGL;
    assign is_pair = (ins & M_PAIR) == V_PAIR;
    assign is_dbl  = (ins & M_PAIR) == V_DBL;
    assign is_srd  = (ins & M_STAT) == V_SRD;
    assign is_swr  = (ins & M_STAT) == V_SWR;
    assign is_mul  = (ins & M_MUL) == V_MUL;
    assign is_neg  = (ins & M_NEG) == V_NEG;
    assign bad_t   = (t == REG_PC) || (t == REG_SP);
    assign bad_t2  = (t2 == REG_PC) || (t2 == REG_SP);

    // Encodings with no defined result are dropped and reported
    assign unp = ((is_sgl || is_swr) && bad_t)
               || ((is_pair || is_dbl)
                   && (bad_t || bad_t2 || (dir && t == t2)))
               || (is_pair && sb == SREG_LAST)
               || (is_dbl && dm[4]);

    // Status ops execute one cycle late, in the drain cycle
    assign go   = (q.st == ST_DRAIN) || (acc && !(is_srd || is_swr));
    assign live = go && cur.cond_pass && q.en;

    assign src_a   = q.bank[sa];
    assign src_b   = q.bank[sb];
    assign src_b1  = q.bank[sb1];
    assign neg_val = {~src_b[31], src_b[30:0]};

    fmnd_fmul u_fmul
    (
        .a   (src_a),
        .b   (src_b),
        .y   (mul_y),
        .exc (mul_x)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d          = q;
        set        = '0;
        clr        = '0;
        d.cwr.va   = 1'b0;
        d.cwr.vb   = 1'b0;
        d.flg.v    = 1'b0;
        d.undef    = 1'b0;
        d.done     = go;
        d.fpx      = 5'h00;
        // Sequencer: status ops stall the issue port for one cycle
        if (q.st == ST_DRAIN)
            d.st = ST_RUN;
        else if (acc && (is_srd || is_swr))
        begin
            d.st   = ST_DRAIN;
            d.pend = issue;
        end
        // Execute
        if (go && cur.cond_pass && !q.en)
        begin
            d.undef         = 1'b1;
            set[EV_UNDEF]   = 1'b1;
        end
        else if (live && unp)
            set[EV_UNPRED]  = 1'b1;
        else if (live)
        begin
            if (is_sgl)
            begin
                if (dir)
                begin
                    d.cwr.va = 1'b1;
                    d.cwr.ia = t;
                    d.cwr.da = src_a;
                end
                else
                    d.bank[sa] = cur.rt_val;
            end
            else if (is_pair)
            begin
                if (dir)
                begin
                    d.cwr.va = 1'b1;
                    d.cwr.ia = t;
                    d.cwr.da = src_b;
                    d.cwr.vb = 1'b1;
                    d.cwr.ib = t2;
                    d.cwr.db = src_b1;
                end
                else
                begin
                    d.bank[sb]  = cur.rt_val;
                    d.bank[sb1] = cur.rt2_val;
                end
            end
            else if (is_dbl)
            begin
                if (dir)
                begin
                    d.cwr.va = 1'b1;
                    d.cwr.ia = t;
                    d.cwr.da = q.bank[dlo];
                    d.cwr.vb = 1'b1;
                    d.cwr.ib = t2;
                    d.cwr.db = q.bank[dhi];
                end
                else
                begin
                    d.bank[dlo] = cur.rt_val;
                    d.bank[dhi] = cur.rt2_val;
                end
            end
            else if (is_srd)
            begin
                if (t == REG_PC)
                begin
                    d.flg.v    = 1'b1;
                    d.flg.nzcv = q.fsc[NZCV_LSB +: 4];
                end
                else
                begin
                    d.cwr.va = 1'b1;
                    d.cwr.ia = t;
                    d.cwr.da = q.fsc;
                end
            end
            else if (is_swr)
                d.fsc = cur.rt_val;
            else if (is_mul)
            begin
                d.bank[sd] = mul_y;
                d.fpx      = mul_x;
                set[EV_FPX +: 5] = mul_x;
            end
            else if (is_neg)
                d.bank[sd] = neg_val;
        end
        // Bus data phase: control, event clear, mask
        if (q.ph_v && q.ph_w)
        begin
            case (q.ph_a)
                A_CTRL:  d.en   = hwdata[0];
                A_EVT:   clr    = hwdata[EV_W-1:0];
                A_MASK:  d.mask = hwdata[EV_W-1:0];
                default: d.en   = q.en;
            endcase
        end
        // A new event in the clearing cycle survives
        d.evt  = (q.evt & ~clr) | set;
        // Bus address phase; read data is caught now so it is ready next cycle
        d.ph_v = hsel && htrans[1] && hready;
        d.ph_w = hwrite;
        d.ph_a = haddr[7:0];
        d.rdat = 32'h0000_0000;
        if (hsel && htrans[1] && hready && !hwrite)
        begin
            case (haddr[7:0])
                A_CTRL:  d.rdat = {31'h0, q.en};
                A_FSC:   d.rdat = q.fsc;
                A_EVT:   d.rdat = {25'h0, q.evt};
                A_MASK:  d.rdat = {25'h0, q.mask};
                default: d.rdat = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q      <= '0;
            q.en   <= EN_RST;
            q.fsc  <= FSC_RST;
            q.mask <= MASK_RST;
            q.st   <= ST_RUN;
        end
        else
            q <= d;
    end

    // Zero-wait slave; every transfer answers OKAY
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign hrdata      = q.rdat;
    assign irq         = |(q.evt & q.mask);
    assign issue_ready = (q.st == ST_RUN);
    assign core_wr     = q.cwr;
    assign flags_wr    = q.flg;
    assign undef       = q.undef;
    assign done        = q.done;
    assign fp_exc      = q.fpx;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_undef_on_off: assert property (
        acc && issue.cond_pass && !q.en && !is_srd && !is_swr
        |=> undef && q.evt[EV_UNDEF] && !core_wr.va)
        else $error("disabled op did not raise undefined");

    a_sgl_to_core: assert property (
        live && is_sgl && dir && !unp
        |=> core_wr.va && core_wr.ia == $past(t) && core_wr.da == $past(src_a))
        else $error("single move to core wrong");

    a_sgl_bad_reg: assert property (
        live && is_sgl && bad_t |=> !core_wr.va && q.evt[EV_UNPRED])
        else $error("single move with bad core index took effect");

    a_pair_order: assert property (
        live && is_pair && dir && !unp
        |=> core_wr.da == $past(src_b) && core_wr.db == $past(src_b1))
        else $error("pair move order wrong");

    a_pair_last: assert property (
        live && is_pair && sb == SREG_LAST |=> !core_wr.va && q.evt[EV_UNPRED])
        else $error("pair move from last register took effect");

    a_same_core: assert property (
        live && (is_pair || is_dbl) && dir && t == t2 |=> !core_wr.vb)
        else $error("equal core indices took effect");

    a_dbl_split: assert property (
        live && is_dbl && dir && !unp
        |=> core_wr.da == $past(q.bank[dlo]) && core_wr.db == $past(q.bank[dhi])
            && core_wr.ia == $past(t) && core_wr.ib == $past(t2) && core_wr.vb)
        else $error("double move halves wrong");

    a_srd_flags: assert property (
        acc && issue.cond_pass && q.en && is_srd && t == REG_PC
        |=> !issue_ready ##1 flags_wr.v && !core_wr.va)
        else $error("status read to flags not after drain");

    a_swr_load: assert property (
        acc && issue.cond_pass && q.en && is_swr && !bad_t
        |=> !issue_ready ##1 q.fsc == $past(issue.rt_val, 2))
        else $error("status write did not load");

    a_neg_sign: assert property (
        live && is_neg && !unp |=> q.bank[$past(sd)] == $past(neg_val))
        else $error("negate result wrong");

    a_mul_write: assert property (
        live && is_mul
        |=> q.bank[$past(sd)] == $past(mul_y) && fp_exc == $past(mul_x))
        else $error("multiply result or flags wrong");

    c_sgl_to_core: cover property (live && is_sgl && dir ##1 core_wr.va);
    c_srd_flags:   cover property (acc && is_srd ##2 flags_wr.v);
    c_irq_raise:   cover property (!irq ##1 irq);

endmodule

/* File: verif/fmnd_core_model.sv */
// Behavioural core register file that feeds operands and takes results
`timescale 1ns/1ps
module fmnd_core_model
(
    input  wire logic                hclk,
    input  wire logic [31:0]         instr,
    input  wire fmnd_pkg::fmnd_cwr_s core_wr,
    input  wire fmnd_pkg::fmnd_flg_s flags_wr,
    output logic      [31:0]         rt_val,
    output logic      [31:0]         rt2_val
);
    import fmnd_pkg::*;
    logic [31:0] regs_q [16];
    logic [3:0]  nzcv_q;
    // Operands follow the register file at once, as the core offers them
    assign rt_val  = regs_q[instr[RT_LSB+:4]];
    assign rt2_val = regs_q[instr[RT2_LSB+:4]];
    // Plain always so the bench may preload registers between instructions
    always @(posedge hclk)
    begin
        if (core_wr.va)
            regs_q[core_wr.ia] <= core_wr.da;
        if (core_wr.vb)
            regs_q[core_wr.ib] <= core_wr.db;
        if (flags_wr.v)
            nzcv_q <= flags_wr.nzcv;
    end
endmodule

/* File: verif/tb_fp_move_mul_neg_decode.sv */
// Random and corner-case bench of the fp move, multiply and negate decoder
`timescale 1ns/1ps
module tb_fp_move_mul_neg_decode;
    import fmnd_pkg::*;
    localparam logic [31:0] TOC = 32'h1 << DIR_BIT;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, irq, ivalid, icond;
    logic        issue_ready, undef, done, un, hresp;
    logic [1:0]  htrans;
    logic [4:0]  fp_exc, fe;
    logic [31:0] haddr, hwdata, hrdata, iins, rt_val, rt2_val, rd, v, w;
    fmnd_cwr_s   core_wr, cw;
    fmnd_flg_s   flags_wr, fw;
    int          bad_count, checked, k;
    // Multiply corners: plain, overflow, inf times zero, denormal input, underflow
    logic [31:0] ma [5] = '{32'h40000000, 32'h7F000000, 32'h7F800000, 32'h00000001, 32'h00800000};
    logic [31:0] mb [5] = '{32'h40400000, 32'h7F000000, 32'h00000000, 32'h40000000, 32'h00800000};
    logic [31:0] my [5] = '{32'h40C00000, 32'h7F800000, 32'h7FC00000, 32'h00000000, 32'h00000000};
    logic [4:0]  mx [5] = '{5'h00, 5'h05, 5'h08, 5'h10, 5'h03};
    // Core index 15 or 13, float index 31, equal core targets, double above the bank
    logic [31:0] up [9] = '{32'hEE00FA10, 32'hEE10DA10, 32'hEC421A3F, 32'hEC4D1A10,
                            32'hEC533A10, 32'hEC544B10, 32'hEC41FB10, 32'hEEE1DA10,
                            32'hEC421B30};
    fmnd_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .issue_valid(ivalid),
        .issue(fmnd_issue_s'({iins, icond, rt_val, rt2_val})), .issue_ready(issue_ready),
        .core_wr(core_wr), .flags_wr(flags_wr), .undef(undef), .done(done), .fp_exc(fp_exc));
    fmnd_core_model gold_u (.hclk(hclk), .instr(iins), .core_wr(core_wr),
        .flags_wr(flags_wr), .rt_val(rt_val), .rt2_val(rt2_val));
    // Free-running 20 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // Float index: four-bit field plus a one-bit extension
    function automatic logic [31:0] sx(int i, int lsb, int xb);
        return (32'(i >> 1) << lsb) | (32'(i & 1) << xb);
    endfunction
    function automatic logic [31:0] two(int t, int t2);
        return (32'(t) << RT_LSB) | (32'(t2) << RT2_LSB);
    endfunction
    function automatic logic [31:0] fneg(logic [31:0] x);
        return {~x[31], x[30:0]};
    endfunction
    function automatic logic sg(int s);
        return (s == 0) ? hreadyout : ((s == 1) ? issue_ready : done);
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Negedge look equals what the next rising edge samples, so no race
    task automatic wait_hi(input int s, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge hclk);
            n++;
        end
        while (sg(s) !== 1'b1 && n < lim);
        if (sg(s) !== 1'b1)
        begin
            bad_count++;
            $display("Error handshake timeout %0d", s);
            close_out();
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        wait_hi(0, 20);
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        wait_hi(0, 20);
        rd = hrdata;
    endtask
    // Offer one instruction, then capture the result pulses beside done
    task automatic iss(input logic [31:0] ins);
        @(posedge hclk);
        ivalid <= 1'b1;
        iins   <= ins;
        wait_hi(1, 20);
        @(posedge hclk);
        ivalid <= 1'b0;
        wait_hi(2, 4);
        cw = core_wr;
        fw = flags_wr;
        un = undef;
        fe = fp_exc;
    endtask
    // Preload a core register on a rising edge, so operands change with the clock
    task pre(input int r, input logic [31:0] d);
        @(posedge hclk);
        gold_u.regs_q[r] <= d;
    endtask
    task automatic put(input int i, input logic [31:0] d);
        pre(2, d);
        iss(V_SGL | sx(i, VA_LSB, XA_BIT) | two(2, 0));
    endtask
    task automatic get(input int i);
        iss(V_SGL | TOC | sx(i, VA_LSB, XA_BIT) | two(3, 0));
        rd = cw.da;
    endtask
    initial
    begin
        {hresetn, hsel, hwrite, ivalid, haddr, htrans, hwdata, iins} = '0;
        bad_count = 0;
        checked = 0;
        icond = 1'b1;
        for (int i = 0; i < 16; i++)
            gold_u.regs_q[i] = 32'h0;
        v = $urandom(32'h65C2);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // Unit off: undefined event, interrupt, clear, unmapped read
        ahb(1'b0, A_CTRL, 32'h0);
        chk("ctrl", 32'h0, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        ahb(1'b1, A_MASK, 32'h7F);
        iss(V_SGL | two(2, 0));
        chk("undef", 32'h1, {31'h0, un});
        ahb(1'b0, A_EVT, 32'h0);
        chk("evt", 32'h1, rd);
        chk("irq", 32'h1, {31'h0, irq});
        ahb(1'b1, A_EVT, 32'h1);
        ahb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("irq", 32'h0, {31'h0, irq});
        ahb(1'b1, A_CTRL, 32'h1);
        $display("test registers done");
        // Failed condition leaves the bank alone; random singles round trip
        put(4, 32'h12345678);
        @(posedge hclk);
        icond <= 1'b0;
        put(4, 32'hFFFFFFFF);
        @(posedge hclk);
        icond <= 1'b1;
        get(4);
        chk("cond", 32'h12345678, rd);
        for (int i = 0; i < 8; i++)
        begin
            k = (i == 0) ? 31 : int'($urandom % 31);
            v = $urandom;
            put(k, v);
            get(k);
            chk("single", v, rd);
        end
        $display("test singles done");
        // Pair in, pair out to other core registers, then double both ways
        k = int'($urandom % 31);
        w = $urandom;
        pre(6, v);
        pre(9, w);
        iss(V_PAIR | sx(k, VB_LSB, XB_BIT) | two(6, 9));
        get(k);
        chk("pair_lo", v, rd);
        get(k + 1);
        chk("pair_hi", w, rd);
        iss(V_PAIR | TOC | sx(k, VB_LSB, XB_BIT) | two(7, 8));
        chk("pair_a", v, cw.da);
        chk("pair_b", w, cw.db);
        k = int'($urandom % 16);
        iss(V_DBL | 32'(k) | two(6, 9));
        get(2 * k);
        chk("dbl_lo", v, rd);
        get(2 * k + 1);
        chk("dbl_hi", w, rd);
        iss(V_DBL | TOC | 32'(k) | two(10, 11));
        chk("dbl_a", v, cw.da);
        chk("dbl_b", w, cw.db);
        $display("test pairs done");
        // Unpredictable encodings raise their event and write nothing
        foreach (up[i])
        begin
            iss(up[i]);
            chk("unp_wr", 32'h0, {31'h0, cw.va});
            ahb(1'b0, A_EVT, 32'h0);
            chk("unp_evt", 32'h2, rd & 32'h2);
            ahb(1'b1, A_EVT, 32'h2);
        end
        // Multiply corners with their flags, then negate
        for (int i = 0; i < 5; i++)
        begin
            put(1, ma[i]);
            put(2, mb[i]);
            iss(V_MUL | sx(17, VD_LSB, XD_BIT) | sx(1, VA_LSB, XA_BIT) | sx(2, VB_LSB, XB_BIT));
            chk("mul_exc", {27'h0, mx[i]}, {27'h0, fe});
            get(17);
            chk("mul", my[i], rd);
        end
        put(5, v);
        iss(V_NEG | sx(20, VD_LSB, XD_BIT) | sx(5, VB_LSB, XB_BIT));
        get(20);
        chk("neg", fneg(v), rd);
        $display("test arithmetic done");
        // Status write, read back as a word and as flags
        pre(4, w);
        iss(V_SWR | two(4, 0));
        ahb(1'b0, A_FSC, 32'h0);
        chk("fsc", w, rd);
        iss(V_SRD | two(5, 0));
        chk("srd", w, cw.da);
        iss(V_SRD | two(15, 0));
        chk("flags", {28'h1, w[31:28]}, {27'h0, fw});
        @(negedge hclk);
        chk("core_flags", {28'h0, w[31:28]}, {28'h0, gold_u.nzcv_q});
        $display("test status done");
        close_out();
    end
endmodule
